// *** hdl/multiturn_wrap_counter.sv ***
// Multiturn revolution counter with programmable wrap and mismatch alarm
`timescale 1ns/1ps
`include "wrap_counter_consts.svh"
module multiturn_wrap_counter
  import wrap_counter_pkg::*;
#(
  parameter int WIDTH = `WRAP_WIDTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Restart strobe (control power cycle), same clock
  input  wire logic             restart,
  // Settings from the parameter host
  input  wire logic [WIDTH-1:0] multiturn_wrap_value,
  input  wire logic [3:0]       encoder_usage_select,
  input  wire logic             encoder_is_absolute,
  // Encoder side, same clock
  input  wire logic [WIDTH-1:0] encoder_limit,
  input  wire logic [WIDTH-1:0] encoder_stored_count,
  input  wire logic             step_fwd,
  input  wire logic             step_rev,
  // Results
  output logic [WIDTH-1:0]      multiturn_count,
  output logic                  limit_mismatch_alarm,
  output logic                  absolute_mode,
  output logic                  running
);
  ////////////////////////////////////////////////////////////////////////
  run_state_e     state;
  logic [WIDTH-1:0] limit;
  logic [WIDTH-1:0] enc_limit;
  wrap_step_if    s ();

  // Wrap needs an absolute encoder and the usage digit set to absolute
  wire usage_abs  = (encoder_usage_select == `USAGE_ABSOLUTE);
  wire next_abs   = encoder_is_absolute && usage_abs;
  wire limits_mis = (limit != enc_limit);

  assign s.fwd        = (state == st_run) && step_fwd;
  assign s.rev        = (state == st_run) && step_rev;
  assign s.count      = multiturn_count;
  assign s.limit      = limit;
  assign s.apply_wrap = absolute_mode;

  wrap_step u_step (
    .s (s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Settings sampled only at restart so a live edit cannot skew the count
  always_ff @(posedge clock) begin
    if (rst) begin
      limit         <= `WRAP_DEFAULT;
      enc_limit     <= `WRAP_DEFAULT;
      absolute_mode <= 1'b1;
    end else if (restart) begin
      limit         <= multiturn_wrap_value;
      enc_limit     <= encoder_limit;
      absolute_mode <= next_abs;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= st_idle;
    end else if (restart) begin
      state <= st_run;
    end
  end

  // Count resumes from the encoder's retained position at restart
  always_ff @(posedge clock) begin
    if (rst) begin
      multiturn_count <= `COUNT_RESET;
    end else if (restart) begin
      multiturn_count <= encoder_stored_count;
    end else begin
      multiturn_count <= s.next_count;
    end
  end

  // Alarm follows the latched pair; cleared only via rst or a later restart
  always_ff @(posedge clock) begin
    if (rst) begin
      limit_mismatch_alarm <= 1'b0;
    end else begin
      limit_mismatch_alarm <= (state == st_run) && !restart && limits_mis;
    end
  end

  assign running = (state == st_run);

  ////////////////////////////////////////////////////////////////////////
  sequence at_top_fwd_s;
    running && !restart && absolute_mode && step_fwd && !step_rev
      && (multiturn_count == limit);
  endsequence

  sequence at_zero_rev_s;
    running && !restart && absolute_mode && step_rev && !step_fwd
      && (multiturn_count == 16'h0000);
  endsequence

  // Restart with equal limits, then one running cycle
  sequence restart_match_s;
    (restart && multiturn_wrap_value == encoder_limit) ##1 !restart;
  endsequence

  fwd_wrap_zero_a: assert property (@(posedge clock) disable iff (rst)
    at_top_fwd_s |=> (multiturn_count == 16'h0000))
    else $error("forward step at limit did not wrap to zero");

  rev_wrap_load_a: assert property (@(posedge clock) disable iff (rst)
    at_zero_rev_s |=> (multiturn_count == $past(limit)))
    else $error("reverse step at zero did not load the limit");

  default_roll_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && step_fwd && !step_rev && multiturn_count == 16'hffff)
      |=> (multiturn_count == 16'h0000))
    else $error("full range roll failed");

  incr_no_wrap_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && !absolute_mode && step_fwd && !step_rev
      && multiturn_count == limit && limit != 16'hffff)
      |=> (multiturn_count == $past(multiturn_count) + 16'h0001))
    else $error("wrap applied without absolute encoder");

  mismatch_alarm_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && limit != enc_limit) |=> limit_mismatch_alarm)
    else $error("mismatch not alarmed");

  restart_alarm_a: assert property (@(posedge clock) disable iff (rst)
    (restart && multiturn_wrap_value != encoder_limit) ##1 !restart
      |=> limit_mismatch_alarm)
    else $error("alarm missing after restart with changed limit");

  usage_select_a: assert property (@(posedge clock) disable iff (rst)
    (restart && encoder_usage_select == 4'h1) |=> !absolute_mode)
    else $error("incremental usage not honoured");

  retain_pos_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> (multiturn_count == $past(encoder_stored_count)))
    else $error("retained position not loaded");

  limit_hold_a: assert property (@(posedge clock) disable iff (rst)
    !restart |=> $stable(limit))
    else $error("limit changed outside restart");

  ////////////////////////////////////////////////////////////////////////
  // Single-step arithmetic, count holds and the plain reverse roll at zero
  fwd_step_plus_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && step_fwd && !step_rev
      && !(absolute_mode && multiturn_count == limit))
      |=> (multiturn_count == $past(multiturn_count) + 16'h0001))
    else $error("forward step did not add one turn");

  rev_step_minus_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && step_rev && !step_fwd && multiturn_count != 16'h0000)
      |=> (multiturn_count == $past(multiturn_count) - 16'h0001))
    else $error("reverse step did not remove one turn");

  both_steps_hold_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && step_fwd && step_rev) |=> $stable(multiturn_count))
    else $error("opposite steps together moved the count");

  quiet_count_hold_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && !step_fwd && !step_rev) |=> $stable(multiturn_count))
    else $error("count moved without a step");

  idle_count_hold_a: assert property (@(posedge clock) disable iff (rst)
    (!running && !restart) |=> $stable(multiturn_count))
    else $error("count moved before the first restart");

  incr_rev_roll_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && !absolute_mode && step_rev && !step_fwd
      && multiturn_count == 16'h0000)
      |=> (multiturn_count == 16'hffff))
    else $error("plain reverse roll at zero failed");

  ////////////////////////////////////////////////////////////////////////
  // Latching and alarm clearing around restart
  type_gate_a: assert property (@(posedge clock) disable iff (rst)
    (restart && !encoder_is_absolute) |=> !absolute_mode)
    else $error("wrap enabled without absolute encoder");

  usage_abs_a: assert property (@(posedge clock) disable iff (rst)
    (restart && encoder_is_absolute && encoder_usage_select == 4'h0) |=> absolute_mode)
    else $error("absolute usage not honoured");

  limit_latch_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> (limit == $past(multiturn_wrap_value)))
    else $error("wrap value not latched at restart");

  enc_latch_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> (enc_limit == $past(encoder_limit)))
    else $error("encoder limit not latched at restart");

  // The alarm needs one running cycle after restart to settle
  restart_clear_a: assert property (@(posedge clock) disable iff (rst)
    restart |=> !limit_mismatch_alarm)
    else $error("alarm not cleared by restart");

  match_clear_a: assert property (@(posedge clock) disable iff (rst)
    restart_match_s |=> !limit_mismatch_alarm)
    else $error("alarm raised with matching limits");

  alarm_low_a: assert property (@(posedge clock) disable iff (rst)
    (running && !restart && limit == enc_limit) |=> !limit_mismatch_alarm)
    else $error("alarm raised with equal limits");
endmodule

// *** hdl/wrap_counter_consts.svh ***
// Constants for the multiturn wrap counter
`ifndef WRAP_COUNTER_CONSTS_SVH
`define WRAP_COUNTER_CONSTS_SVH
`define WRAP_WIDTH 16
`define WRAP_DEFAULT 16'hffff
`define COUNT_RESET 16'h0000
`define USAGE_ABSOLUTE 4'h0
`define USAGE_INCREMENTAL 4'h1
`endif

// *** hdl/wrap_counter_pkg.sv ***
// Types for the multiturn wrap counter
package wrap_counter_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_run
  } run_state_e;
  typedef logic [15:0] turns_t;
endpackage

// *** hdl/wrap_step.sv ***
// Combinational next-count computation with modulus wrap
`timescale 1ns/1ps
`include "wrap_counter_consts.svh"
module wrap_step
  import wrap_counter_pkg::*;
(
  wrap_step_if.unit s
);
  wire at_top  = s.apply_wrap && (s.count == s.limit);
  wire at_zero = (s.count == `COUNT_RESET);
  wire [15:0] wrap_low = s.apply_wrap ? s.limit : `WRAP_DEFAULT;
  wire [15:0] plus_one  = s.count + 16'h0001;
  wire [15:0] minus_one = s.count - 16'h0001;
  // Default limit gives the plain 16-bit roll, so both paths agree
  assign s.next_count = (s.fwd && !s.rev) ? (at_top ? `COUNT_RESET : plus_one) :
                        (s.rev && !s.fwd) ? (at_zero ? wrap_low : minus_one) :
                        s.count;
endmodule

// *** hdl/wrap_step_if.sv ***
// Step request and wrapped result between counter top and step unit
`timescale 1ns/1ps
interface wrap_step_if;
  logic        fwd;
  logic        rev;
  logic [15:0] count;
  logic [15:0] limit;
  logic        apply_wrap;
  logic [15:0] next_count;
  modport top  (output fwd, output rev, output count, output limit, output apply_wrap,
                input next_count);
  modport unit (input fwd, input rev, input count, input limit, input apply_wrap,
                output next_count);
endinterface

// *** verification/encoder_model.sv ***
// Behavioural encoder with stored limit, retained count and host write path
`timescale 1ns/1ps
module encoder_model (
  input  wire logic        clock,
  input  wire logic        write_limit,
  input  wire logic [15:0] new_limit,
  input  wire logic        save,
  input  wire logic [15:0] count,
  output logic      [15:0] limit,
  output logic      [15:0] stored
);
  initial begin
    limit = 16'hffff;
    stored = 16'h0063;
  end
  always @(posedge clock) begin
    if (write_limit) begin
      limit <= new_limit;
    end
    // Count survives power-off
    if (save) begin
      stored <= count;
    end
  end
endmodule

// *** verification/test_multiturn_wrap_counter.sv ***
// Self-checking bench for the multiturn wrap counter
`timescale 1ns/1ps
module test_multiturn_wrap_counter
  import wrap_counter_pkg::*;
;
  logic clock = 0, rst = 1, restart = 0, fwd = 0, rev = 0, wr = 0, save = 0, enc_abs = 1;
  logic [15:0] wrap = 16'h0063, nlim = 16'h0000, elim, estore, count;
  logic [3:0] usage = 4'h0;
  logic alarm, absm, running;
  int n_mismatch = 0, checks_done = 0;
  logic [17:0] rows [6] = '{{2'b10, 16'h0000}, {2'b01, 16'h0063}, {2'b01, 16'h0062},
                            {2'b10, 16'h0063}, {2'b11, 16'h0063}, {2'b10, 16'h0000}};
  multiturn_wrap_counter multiturn_wrap_counter_i (.clock(clock), .rst(rst),
    .restart(restart), .multiturn_wrap_value(wrap), .encoder_usage_select(usage),
    .encoder_is_absolute(enc_abs), .encoder_limit(elim), .encoder_stored_count(estore),
    .step_fwd(fwd), .step_rev(rev), .multiturn_count(count), .limit_mismatch_alarm(alarm),
    .absolute_mode(absm), .running(running));
  encoder_model encoder_model_i (.clock(clock), .write_limit(wr), .new_limit(nlim),
    .save(save), .count(count), .limit(elim), .stored(estore));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_restart(input logic [15:0] w, input logic [3:0] u);
    @(posedge clock);
    restart <= 1'b1;
    wrap <= w;
    usage <= u;
    @(posedge clock);
    restart <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic step(input logic f, input logic r);
    @(posedge clock);
    fwd <= f;
    rev <= r;
    @(posedge clock);
    fwd <= 1'b0;
    rev <= 1'b0;
    #1;
  endtask
  task automatic host_pulse(input logic w, input logic s, input logic [15:0] v);
    @(posedge clock);
    wr <= w;
    save <= s;
    nlim <= v;
    @(posedge clock);
    wr <= 1'b0;
    save <= 1'b0;
    #1;
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    step(1'b1, 1'b0);
    chk({running, alarm, count[13:0]}, 16'h0000);
    // Drive limit 99 against encoder default, then fix it from the host side
    do_restart(16'h0063, 4'h0);
    chk({15'h0, alarm}, 16'h0001);
    host_pulse(1'b1, 1'b0, 16'h0063);
    chk({15'h0, alarm}, 16'h0001);
    do_restart(16'h0063, 4'h0);
    chk({14'h0, alarm, absm}, 16'h0001);
    chk(count, 16'h0063);
    foreach (rows[i]) begin
      step(rows[i][17], rows[i][16]);
      chk(count, rows[i][15:0]);
    end
    // Wrap setting changed while running must not take effect
    @(posedge clock);
    wrap <= 16'h0002;
    repeat (3) step(1'b1, 1'b0);
    chk(count, 16'h0003);
    // Park count 3 in the encoder so the zero crossing comes quickly
    host_pulse(1'b0, 1'b1, 16'h0063);
    do_restart(16'h0063, 4'h1);
    chk({15'h0, absm}, 16'h0000);
    chk(count, 16'h0003);
    repeat (4) step(1'b0, 1'b1);
    chk(count, 16'hffff);
    host_pulse(1'b1, 1'b1, 16'hffff);
    do_restart(16'hffff, 4'h0);
    step(1'b1, 1'b0);
    chk(count, 16'h0000);
    step(1'b0, 1'b1);
    chk({alarm, count[14:0]}, 16'h7fff);
    // Rotary incremental encoder: limit fffe must not wrap the count
    @(posedge clock);
    enc_abs <= 1'b0;
    do_restart(16'hfffe, 4'h0);
    chk({14'h0, alarm, absm}, 16'h0002);
    step(1'b0, 1'b1);
    step(1'b1, 1'b0);
    chk(count, 16'hffff);
    // Reset in mid-run drops back to idle with steps ignored
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    step(1'b1, 1'b0);
    chk({running, alarm, absm, count[12:0]}, 16'h2000);
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
endmodule
